// ---- src/ppr_top.sv ----
// Remappable pin select logic for the second serial port and pins 8 and 9
`timescale 1ns/1ps
module ppr_top (
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic                          ce,
  input  wire logic [ppr_pkg::PPR_AW-1:0]    reg_addr,
  input  wire logic [ppr_pkg::PPR_DW-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [ppr_pkg::PPR_DW-1:0]    reg_rdata,
  input  wire logic [ppr_pkg::PPR_NPIN-1:0]  remappable_pin,
  input  wire logic [ppr_pkg::PPR_NFUNC-1:0] periph_out,
  output logic                               port2_serial_clock_input,
  output logic                               port2_serial_data_input,
  output logic                               port2_slave_select_input,
  output logic                               pin8_out,
  output logic                               pin9_out
);
  import ppr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [PPR_SW-1:0] port2_clock_in_pin_sel;
    logic [PPR_SW-1:0] port2_data_in_pin_sel;
    logic [PPR_SW-1:0] port2_select_in_pin_sel;
    logic [PPR_SW-1:0] pin9_output_func_sel;
    logic [PPR_SW-1:0] pin8_output_func_sel;
    logic [PPR_DW-1:0] rdata;
    logic              sck;
    logic              sdi;
    logic              ss;
    logic              p8;
    logic              p9;
  } ppr_state_s;

  ppr_state_s st;
  ppr_state_s next_st;
  logic [PPR_NPIN-1:0] pin_sync;

  function automatic logic [PPR_DW-1:0] pack2(input logic [PPR_SW-1:0] hi,
                                              input logic [PPR_SW-1:0] lo);
    logic [PPR_DW-1:0] v;
    v = '0;
    v[FLD_HI_LSB +: PPR_SW] = hi;
    v[FLD_LO_LSB +: PPR_SW] = lo;
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pad synchroniser

  ppr_input_sync #(.W(PPR_NPIN)) u_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .pad_in   (remappable_pin),
    .pad_sync (pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and routing

  always_comb begin
    next_st = st;
    if (reg_wr) begin
      case (reg_addr)
        OFF_SPI2_CLK_DATA: begin
          next_st.port2_clock_in_pin_sel = reg_wdata[FLD_HI_LSB +: PPR_SW];
          next_st.port2_data_in_pin_sel  = reg_wdata[FLD_LO_LSB +: PPR_SW];
        end
        OFF_SPI2_SELECT: begin
          next_st.port2_select_in_pin_sel = reg_wdata[FLD_LO_LSB +: PPR_SW];
        end
        OFF_PINS_8_9_MAP: begin
          next_st.pin9_output_func_sel = reg_wdata[FLD_HI_LSB +: PPR_SW];
          next_st.pin8_output_func_sel = reg_wdata[FLD_LO_LSB +: PPR_SW];
        end
        default: begin
        end
      endcase
    end
    next_st.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFF_SPI2_CLK_DATA: next_st.rdata = pack2(st.port2_clock_in_pin_sel,
                                                 st.port2_data_in_pin_sel);
        OFF_SPI2_SELECT:   next_st.rdata = pack2('0, st.port2_select_in_pin_sel);
        OFF_PINS_8_9_MAP:  next_st.rdata = pack2(st.pin9_output_func_sel,
                                                 st.pin8_output_func_sel);
        default:           next_st.rdata = '0;
      endcase
    end
    // Routing uses the stored selectors; takes effect one cycle after a write
    next_st.sck = pin_sync[st.port2_clock_in_pin_sel];
    next_st.sdi = pin_sync[st.port2_data_in_pin_sel];
    next_st.ss  = pin_sync[st.port2_select_in_pin_sel];
    next_st.p9  = periph_out[st.pin9_output_func_sel];
    next_st.p8  = periph_out[st.pin8_output_func_sel];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st                         <= '0;
      st.port2_clock_in_pin_sel  <= RST_INPUT_SEL;
      st.port2_data_in_pin_sel   <= RST_INPUT_SEL;
      st.port2_select_in_pin_sel <= RST_INPUT_SEL;
      st.pin9_output_func_sel    <= RST_OUTPUT_SEL;
      st.pin8_output_func_sel    <= RST_OUTPUT_SEL;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign reg_rdata                = st.rdata;
  assign port2_serial_clock_input = st.sck;
  assign port2_serial_data_input  = st.sdi;
  assign port2_slave_select_input = st.ss;
  assign pin8_out                 = st.p8;
  assign pin9_out                 = st.p9;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_wr_sel_hi;
    @(posedge clk) disable iff (!arst_n)
      (ce && reg_wr && reg_addr == OFF_SPI2_CLK_DATA)
        |=> (st.port2_clock_in_pin_sel == $past(reg_wdata[12:8]));
  endproperty
  a_wr_sel_hi: assert property (p_wr_sel_hi) else $error("clock select not stored");

  property p_route_sck;
    @(posedge clk) disable iff (!arst_n)
      ce ##1 ce |-> port2_serial_clock_input == $past(pin_sync[st.port2_clock_in_pin_sel]);
  endproperty
  a_route_sck: assert property (p_route_sck) else $error("clock input misrouted");

  property p_route_sdi;
    @(posedge clk) disable iff (!arst_n)
      ce ##1 ce |-> port2_serial_data_input == $past(pin_sync[st.port2_data_in_pin_sel]);
  endproperty
  a_route_sdi: assert property (p_route_sdi) else $error("data input misrouted");

  property p_route_ss;
    @(posedge clk) disable iff (!arst_n)
      ce ##1 ce |-> port2_slave_select_input == $past(pin_sync[st.port2_select_in_pin_sel]);
  endproperty
  a_route_ss: assert property (p_route_ss) else $error("select input misrouted");

  property p_route_p9;
    @(posedge clk) disable iff (!arst_n)
      ce ##1 ce |-> pin9_out == $past(periph_out[st.pin9_output_func_sel]);
  endproperty
  a_route_p9: assert property (p_route_p9) else $error("pin 9 misrouted");

  property p_route_p8;
    @(posedge clk) disable iff (!arst_n)
      ce ##1 ce |-> pin8_out == $past(periph_out[st.pin8_output_func_sel]);
  endproperty
  a_route_p8: assert property (p_route_p8) else $error("pin 8 misrouted");

  property p_unused_zero;
    @(posedge clk) disable iff (!arst_n)
      reg_rdata[15:13] == 3'h0 && reg_rdata[7:5] == 3'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits nonzero");

  property p_sel_reg_zero;
    @(posedge clk) disable iff (!arst_n)
      (ce && reg_rd && reg_addr == OFF_SPI2_SELECT) |=> reg_rdata[15:5] == 11'h000;
  endproperty
  a_sel_reg_zero: assert property (p_sel_reg_zero) else $error("select reg upper bits set");

  property p_next_cycle;
    @(posedge clk) disable iff (!arst_n)
      (ce && reg_wr && reg_addr == OFF_PINS_8_9_MAP) ##1 ce
        |-> (st.pin8_output_func_sel == $past(reg_wdata[FLD_LO_LSB +: PPR_SW]))
        ##1 (pin8_out == $past(periph_out[st.pin8_output_func_sel]));
  endproperty
  a_next_cycle: assert property (p_next_cycle) else $error("routing change late");

  property p_wr_sel_lo;
    @(posedge clk) disable iff (!arst_n)
      (ce && reg_wr && reg_addr == OFF_SPI2_CLK_DATA)
        |=> (st.port2_data_in_pin_sel == $past(reg_wdata[FLD_LO_LSB +: PPR_SW]));
  endproperty
  a_wr_sel_lo: assert property (p_wr_sel_lo) else $error("data select not stored");

  property p_wr_sel_ss;
    @(posedge clk) disable iff (!arst_n)
      (ce && reg_wr && reg_addr == OFF_SPI2_SELECT)
        |=> (st.port2_select_in_pin_sel == $past(reg_wdata[FLD_LO_LSB +: PPR_SW]));
  endproperty
  a_wr_sel_ss: assert property (p_wr_sel_ss) else $error("slave select not stored");

  property p_wr_map_p9;
    @(posedge clk) disable iff (!arst_n)
      (ce && reg_wr && reg_addr == OFF_PINS_8_9_MAP)
        |=> (st.pin9_output_func_sel == $past(reg_wdata[FLD_HI_LSB +: PPR_SW]));
  endproperty
  a_wr_map_p9: assert property (p_wr_map_p9) else $error("pin 9 map not stored");

  property p_wr_map_p8;
    @(posedge clk) disable iff (!arst_n)
      (ce && reg_wr && reg_addr == OFF_PINS_8_9_MAP)
        |=> (st.pin8_output_func_sel == $past(reg_wdata[FLD_LO_LSB +: PPR_SW]));
  endproperty
  a_wr_map_p8: assert property (p_wr_map_p8) else $error("pin 8 map not stored");

  property p_rdata_idle;
    @(posedge clk) disable iff (!arst_n)
      (ce && !reg_rd) |=> (reg_rdata == '0);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

  property p_ce_freeze;
    @(posedge clk) disable iff (!arst_n)
      !ce |=> $stable(st);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");
endmodule // ppr_top

// ---- src/ppr_pkg.sv ----
// Constants for the peripheral pin remap block
package ppr_pkg;
  localparam int          PPR_AW             = 4;
  localparam int          PPR_DW             = 16;
  localparam int          PPR_SW             = 5;
  localparam int          PPR_NPIN           = 32;
  localparam int          PPR_NFUNC          = 32;
  localparam logic [3:0]  OFF_SPI2_CLK_DATA  = 4'h0;
  localparam logic [3:0]  OFF_SPI2_SELECT    = 4'h1;
  localparam logic [3:0]  OFF_PINS_8_9_MAP   = 4'h2;
  localparam int          FLD_HI_LSB         = 8;
  localparam int          FLD_LO_LSB         = 0;
  localparam logic [4:0]  RST_INPUT_SEL      = 5'h1F;
  localparam logic [4:0]  RST_OUTPUT_SEL     = 5'h00;
  localparam int          SYNC_STAGES        = 3;
endpackage

// ---- src/ppr_input_sync.sv ----
// Three-stage pad synchroniser with agreement filter
`timescale 1ns/1ps
module ppr_input_sync #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] pad_in,
  output logic      [W-1:0] pad_sync
);
  import ppr_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ppr_sync_s;

  ppr_sync_s st;
  ppr_sync_s next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = pad_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign pad_sync = st.q;
endmodule // ppr_input_sync

// ---- sim/ppr_far_model.sv ----
// Pads and peripheral outputs facing the remap block
`timescale 1ns/1ps
module ppr_far_model (
  input  wire logic                          clk,
  input  wire logic [ppr_pkg::PPR_NPIN-1:0]  pad_val,
  input  wire logic [ppr_pkg::PPR_NFUNC-1:0] func_val,
  output logic      [ppr_pkg::PPR_NPIN-1:0]  remappable_pin,
  output logic      [ppr_pkg::PPR_NFUNC-1:0] periph_out
);
  import ppr_pkg::*;
  // Both change just after a rising edge
  always_ff @(posedge clk) begin
    remappable_pin <= pad_val;
    periph_out     <= func_val;
  end
endmodule // ppr_far_model

// ---- sim/peripheral_pin_remap_test.sv ----
// Self-checking bench for the pin remap block
`timescale 1ns/1ps
module peripheral_pin_remap_test;
  import ppr_pkg::*;
  logic        clk = 0, arst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0]  reg_addr = 0, a;
  logic [15:0] reg_wdata = 0, reg_rdata;
  logic [31:0] pad_val = 32'h80000001, func_val = 32'h00000001, remappable_input_only_pin, pout;
  logic        ck_in, dat_in, sel_in, p8, p9;
  int          mdl[16];
  int          bad_count = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  ppr_top DUT (.clk(clk), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .remappable_pin(remappable_input_only_pin), .periph_out(pout), .port2_serial_clock_input(ck_in),
    .port2_serial_data_input(dat_in), .port2_slave_select_input(sel_in),
    .pin8_out(p8), .pin9_out(p9));
  ppr_far_model far (.clk(clk), .pad_val(pad_val), .func_val(func_val),
    .remappable_pin(remappable_input_only_pin), .periph_out(pout));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [15:0] dd);
    @(posedge clk); reg_addr <= ad; reg_wdata <= dd; reg_wr <= 1;
    @(posedge clk); reg_wr <= 0;
    if (ce && ad < 3) mdl[ad] = int'(dd & (ad == 1 ? 16'h001F : 16'h1F1F));
  endtask
  task automatic rd(input logic [3:0] ad);
    @(posedge clk); reg_addr <= ad; reg_rd <= 1;
    @(posedge clk); reg_rd <= 0;
    #1 chk(reg_rdata, 16'(mdl[ad]));
  endtask
  task automatic pins_chk;
    chk(p9, func_val[(mdl[2] >> 8) & 31]);
    chk(p8, func_val[mdl[2] & 31]);
  endtask
  task automatic route;
    repeat (8) @(posedge clk);
    #1 chk(ck_in, pad_val[(mdl[0] >> 8) & 31]);
    chk(dat_in, pad_val[mdl[0] & 31]);
    chk(sel_in, pad_val[mdl[1] & 31]);
    pins_chk();
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    bad_count++;
    results();
  end
  initial begin
    void'($urandom(64));
    mdl[0] = 16'h1F1F;
    mdl[1] = 16'h001F;
    repeat (2) @(posedge clk);
    arst_n <= 1;
    for (int i = 0; i < 4; i++) rd(4'(i));
    route();
    repeat (24) begin
      a = 4'($urandom_range(3));
      wr(a, 16'($urandom));
      rd(a);
      @(posedge clk); pad_val <= $urandom; func_val <= $urandom;
      route();
    end
    // Pin outputs follow one edge after the write edge
    for (int i = 0; i < 8; i++) begin
      wr(4'h2, 16'($urandom));
      @(posedge clk);
      #1 pins_chk();
    end
    // Write strobe ignored while the clock enable is low
    @(posedge clk); ce <= 0;
    wr(4'h0, 16'h0000);
    @(posedge clk); ce <= 1;
    rd(4'h0);
    // Second reset brings back reset selectors
    @(posedge clk); arst_n <= 0;
    @(posedge clk); arst_n <= 1;
    mdl[0] = 16'h1F1F;
    mdl[1] = 16'h001F;
    mdl[2] = 0;
    for (int i = 0; i < 3; i++) rd(4'(i));
    route();
    results();
  end
endmodule // peripheral_pin_remap_test
